// ==== capture_pkg.sv ====
// Package for the position capture channel: register offsets, codes, reset values.
// Assumes a simple parameter register port driven by the fieldbus interface logic.
`default_nettype none
package capture_pkg;
  localparam logic [11:0] ADDR_EDGE_SELECT = 12'h0a04;
  localparam logic [11:0] ADDR_ACTIVATION = 12'h0a08;
  localparam logic [11:0] ADDR_CAPTURED_POSITION = 12'h0a0c;
  localparam logic [11:0] ADDR_EVENT_COUNT = 12'h0a10;
  localparam logic [11:0] ADDR_STATUS_WORD = 12'h0a00;
  localparam logic [15:0] ACT_STOP = 16'h0000;
  localparam logic [15:0] ACT_ONCE = 16'h0001;
  localparam logic [15:0] ACT_CONTINUOUS = 16'h0002;
  localparam logic [15:0] EDGE_SELECT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
  localparam int STATUS_DONE_BIT = 0;
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_ONCE = 3'b010,
    CAP_CONT = 3'b100
  } cap_state_e;
endpackage
`default_nettype wire

// ==== capture_edge_if.sv ====
// Interface carrying the synchronised capture edge from detector to control.
// Assumes one clock domain, clk_sys.
`default_nettype none
interface capture_edge_if;
  logic edge_select;
  logic edge_hit;
  modport detector (input edge_select, output edge_hit);
  modport control (output edge_select, input edge_hit);
endinterface
`default_nettype wire

// ==== capture_edge_detect.sv ====
// Synchroniser and edge detector for the capture input.
// Assumes the input may change at any time relative to clk_sys.
`default_nettype none
module capture_edge_detect (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic capture_input_one,
  capture_edge_if.detector eif
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic hit_reg;
  wire rise = sync2_reg & ~prev_reg;
  wire fall = ~sync2_reg & prev_reg;
  wire hit_next = eif.edge_select ? rise : fall;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= capture_input_one;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      hit_reg <= hit_next;
    end
  end
  assign eif.edge_hit = hit_reg & clk_en;

  a_edge_rise_hit: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && eif.edge_select && sync2_reg && !prev_reg) |=> hit_reg)
    else $error("rising edge not flagged");
  a_edge_fall_hit: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !eif.edge_select && !sync2_reg && prev_reg) |=> hit_reg)
    else $error("falling edge not flagged");
endmodule
`default_nettype wire

// ==== position_capture_unit.sv ====
// Position capture channel: latches drive position on a selected input edge.
// Assumes a single-cycle parameter port from the fieldbus interface logic.
`default_nettype none
// Notes on behaviour
// - Code 0 stops capture; no more positions latched until re-armed.
// - Code 1 arms once; unit disarms after the first latched position.
// - Code 2 arms continuously; every qualifying edge latches.
// - Continuous capture stays armed after each event while code stays 2.
// - Arming accepted only in fieldbus control mode; master selects it first.
// - Edge select 0 captures on falling edge, 1 on rising; default 0.
// - A read-only 16-bit counter counts each capture event.
// - Event counter clears whenever a start code is accepted in fieldbus control mode.
// - Each qualifying edge stores signed 32-bit position in user units.
// - Redefining position reference recomputes stored captured position.
// - After a capture, status word bit 0 is set.
module position_capture_unit
  import capture_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic capture_input_one,
  input wire logic fieldbus_mode,
  input wire logic signed [31:0] position_now,
  input wire logic ref_redefine,
  input wire logic signed [31:0] ref_offset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic capture_armed
);
  import capture_pkg::*;

  capture_edge_if eif ();

  cap_state_e state_reg;
  cap_state_e state_next;
  logic [15:0] edge_select_reg;
  logic [15:0] activation_reg;
  logic [15:0] count_reg;
  logic signed [31:0] position_reg;
  logic [15:0] status_reg;
  logic [31:0] rdata_next;

  capture_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .capture_input_one(capture_input_one),
    .eif(eif)
  );

  assign eif.edge_select = edge_select_reg[0];

  // Register decode
  wire wr_edge = reg_write & (reg_addr == ADDR_EDGE_SELECT);
  wire wr_act = reg_write & (reg_addr == ADDR_ACTIVATION);
  wire [15:0] wcode = reg_wdata[15:0];
  // Start codes are ignored outside fieldbus control mode
  wire start_once = wr_act & (wcode == ACT_ONCE) & fieldbus_mode;
  wire start_cont = wr_act & (wcode == ACT_CONTINUOUS) & fieldbus_mode;
  wire stop_cmd = wr_act & (wcode == ACT_STOP);
  wire start_any = start_once | start_cont;
  wire armed = (state_reg == CAP_ONCE) | (state_reg == CAP_CONT);
  // An activation write in the same cycle as an edge takes precedence: the edge is dropped
  wire capture = armed & eif.edge_hit & ~wr_act;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CAP_IDLE: begin
        if (start_once) state_next = CAP_ONCE;
        else if (start_cont) state_next = CAP_CONT;
      end
      CAP_ONCE: begin
        if (stop_cmd) state_next = CAP_IDLE;
        else if (start_cont) state_next = CAP_CONT;
        else if (capture) state_next = CAP_IDLE;
      end
      CAP_CONT: begin
        if (stop_cmd) state_next = CAP_IDLE;
        else if (start_once) state_next = CAP_ONCE;
        else state_next = CAP_CONT;
      end
      default: state_next = CAP_IDLE;
    endcase
  end

  always_comb begin
    case (reg_addr)
      ADDR_EDGE_SELECT: rdata_next = {16'h0000, edge_select_reg};
      ADDR_ACTIVATION: rdata_next = {16'h0000, activation_reg};
      ADDR_CAPTURED_POSITION: rdata_next = position_reg;
      ADDR_EVENT_COUNT: rdata_next = {16'h0000, count_reg};
      ADDR_STATUS_WORD: rdata_next = {16'h0000, status_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // State and configuration registers, each in its own short block
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= CAP_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edge_select_reg <= EDGE_SELECT_RESET;
    end else if (clk_en && wr_edge) begin
      edge_select_reg <= wcode;
    end
  end

  // Readback shows the last accepted code; a finished one-shot reads as stop
  wire act_load = stop_cmd | start_any;
  wire once_done = (state_reg == CAP_ONCE) & capture;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activation_reg <= ACT_STOP;
    end else if (clk_en) begin
      if (act_load) activation_reg <= wcode;
      else if (once_done) activation_reg <= ACT_STOP;
    end
  end

  // A start and a capture never meet: capture is masked by any activation write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= COUNT_RESET;
    end else if (clk_en) begin
      if (start_any) count_reg <= COUNT_RESET;
      else if (capture) count_reg <= count_reg + 16'h0001;
    end
  end

  // Set wins over clear should the two ever coincide
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_reg <= 16'h0000;
    end else if (clk_en) begin
      if (capture) status_reg[STATUS_DONE_BIT] <= 1'b1;
      else if (start_any) status_reg[STATUS_DONE_BIT] <= 1'b0;
    end
  end

  // Capture wins over a reference change in the same cycle; that shift is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      position_reg <= POSITION_RESET;
    end else if (clk_en) begin
      if (capture) position_reg <= position_now;
      else if (ref_redefine) position_reg <= position_reg + ref_offset;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_read;
      if (reg_read) reg_rdata <= rdata_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_armed <= 1'b0;
    end else if (clk_en) begin
      capture_armed <= (state_next != CAP_IDLE);
    end
  end

  // Checks on the control path
  a_stop_disarms: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && stop_cmd) |=> (state_reg == CAP_IDLE))
    else $error("stop did not disarm");

  a_once_ends: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state_reg == CAP_ONCE && capture) |=> (state_reg == CAP_IDLE))
    else $error("one-shot did not end");

  a_cont_arms: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && start_cont) |=> (state_reg == CAP_CONT))
    else $error("continuous start failed");

  a_cont_stays: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state_reg == CAP_CONT && capture) |=> (state_reg == CAP_CONT))
    else $error("continuous capture ended");

  a_mode_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state_reg == CAP_IDLE && !fieldbus_mode) |=> (state_reg == CAP_IDLE))
    else $error("armed outside fieldbus mode");

  a_count_incr: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && capture) |=> (count_reg == $past(count_reg) + 16'h0001))
    else $error("counter did not increment");

  a_count_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && start_any) |=> (count_reg == 16'h0000))
    else $error("counter not cleared on start");

  a_pos_latch: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && capture) |=> (position_reg == $past(position_now)))
    else $error("position not latched");

  a_pos_recalc: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !capture && ref_redefine)
      |=> (position_reg == $past(position_reg) + $past(ref_offset)))
    else $error("position not recomputed");

  a_status_done: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && capture) |=> status_reg[0])
    else $error("status bit not set");

  a_stop_code: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && stop_cmd) |=> (activation_reg == ACT_STOP))
    else $error("stop code not stored");

  a_idle_no_latch: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !armed && !ref_redefine) |=> (position_reg == $past(position_reg)))
    else $error("idle unit latched a position");

  a_once_arms: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && start_once) |=> (state_reg == CAP_ONCE))
    else $error("one-shot start failed");

  a_once_code_back: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && once_done) |=> (activation_reg == ACT_STOP && !capture_armed))
    else $error("one-shot still shown armed");

  a_armed_out: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en |=> (capture_armed == (state_reg != CAP_IDLE)))
    else $error("armed output disagrees with state");

  a_cont_code_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state_reg == CAP_CONT && capture) |=> (activation_reg == ACT_CONTINUOUS))
    else $error("continuous code lost");

  a_mode_code_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && wr_act && !fieldbus_mode && wcode != ACT_STOP)
      |=> (activation_reg == $past(activation_reg)))
    else $error("start code taken outside fieldbus mode");

  a_edge_stored: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && wr_edge) |=> (edge_select_reg == $past(wcode)))
    else $error("edge select not stored");

  a_edge_default: assert property (@(posedge clk_sys)
    rst |=> (edge_select_reg == EDGE_SELECT_RESET))
    else $error("edge select not reset");

  a_count_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !capture && !start_any) |=> (count_reg == $past(count_reg)))
    else $error("counter moved without event");

  a_rdata_count: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && reg_read && reg_addr == ADDR_EVENT_COUNT)
      |=> (reg_rdata == {16'h0000, $past(count_reg)}))
    else $error("counter readback wrong");

  a_rdata_pos: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && reg_read && reg_addr == ADDR_CAPTURED_POSITION)
      |=> (reg_rdata == $past(position_reg)))
    else $error("position readback wrong");

  a_pos_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !capture && !ref_redefine) |=> (position_reg == $past(position_reg)))
    else $error("position moved without event");

  a_status_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && start_any) |=> !status_reg[STATUS_DONE_BIT])
    else $error("status bit not cleared on start");

  a_status_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !capture && !start_any) |=> $stable(status_reg))
    else $error("status changed without event");

  // Checks on the register port and the clock enable
  a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && reg_read) |=> reg_rvalid)
    else $error("read not answered");

  a_rvalid_low: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !reg_read) |=> !reg_rvalid)
    else $error("read answer without request");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !reg_read) |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_freeze_state: assert property (@(posedge clk_sys) disable iff (rst)
    !clk_en |=> ($stable(state_reg) && $stable(count_reg) && $stable(position_reg)))
    else $error("state moved while clock enable low");

  a_reset_outputs: assert property (@(posedge clk_sys)
    rst |=> (!capture_armed && !reg_rvalid && reg_rdata == 32'h0000_0000))
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ==== capture_source.sv ====
// Model of the external capture signal source feeding the capture input.
// Assumes the bench requests levels; the pin follows them off the clock edge.
`default_nettype none
module capture_source (
  input wire logic level_req,
  output logic capture_input_one
);
  timeunit 1ns;
  timeprecision 1ps;
  initial capture_input_one = 1'b0;
  // Lag puts the edge 3 ns after the rising clock edge, between edges, as a truly asynchronous source would
  always @(level_req) capture_input_one <= #3 level_req;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the position capture channel.
// Assumes the bench acts as the fieldbus master and owns clk_en.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  logic clk_sys = 0, rst = 1, fieldbus_mode = 0, ref_redefine = 0, clk_en = 1;
  logic reg_write = 0, reg_read = 0, level_req = 0, cap_in, reg_rvalid, capture_armed;
  logic signed [31:0] position_now = 0, ref_offset = 0, pos_exp;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  capture_source i_capture_source (.level_req(level_req), .capture_input_one(cap_in));
  position_capture_unit i_position_capture_unit (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .capture_input_one(cap_in), .fieldbus_mode(fieldbus_mode), .position_now(position_now),
    .ref_redefine(ref_redefine), .ref_offset(ref_offset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .capture_armed(capture_armed));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 check({31'h0, reg_rvalid}, 32'h0000_0001);
    check(reg_rdata, e);
  endtask
  // One full high pulse; position is held so either edge sees the same value
  task automatic pulse(input logic signed [31:0] p);
    @(posedge clk_sys);
    position_now <= p;
    level_req <= 1'b1;
    repeat (8) @(posedge clk_sys);
    level_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] shifted(input logic signed [31:0] p, input logic signed [31:0] o);
    return p + o;
  endfunction
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h8a87));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(12'h0a00 + 12'(4 * i), 32'h0000_0000);
    wr(ADDR_ACTIVATION, 32'h0000_0001);
    rd(ADDR_ACTIVATION, 32'h0000_0000);
    @(posedge clk_sys);
    fieldbus_mode <= 1'b1;
    wr(ADDR_EDGE_SELECT, 32'h0000_0001);
    wr(ADDR_ACTIVATION, {16'h0000, ACT_CONTINUOUS});
    for (int i = 1; i <= 3; i++) begin
      pos_exp = $urandom;
      pulse(pos_exp);
      check({31'h0, capture_armed}, 32'h0000_0001);
      rd(ADDR_CAPTURED_POSITION, pos_exp);
      rd(ADDR_EVENT_COUNT, 32'(i));
    end
    rd(ADDR_STATUS_WORD, 32'h0000_0001);
    @(posedge clk_sys);
    ref_offset <= $urandom;
    ref_redefine <= 1'b1;
    @(posedge clk_sys);
    ref_redefine <= 1'b0;
    rd(ADDR_CAPTURED_POSITION, shifted(pos_exp, ref_offset));
    wr(ADDR_ACTIVATION, {16'h0000, ACT_STOP});
    pulse($urandom);
    rd(ADDR_EVENT_COUNT, 32'h0000_0003);
    check({31'h0, capture_armed}, 32'h0000_0000);
    wr(ADDR_EDGE_SELECT, 32'h0000_0000);
    wr(ADDR_ACTIVATION, {16'h0000, ACT_ONCE});
    rd(ADDR_EVENT_COUNT, 32'h0000_0000);
    check({31'h0, capture_armed}, 32'h0000_0001);
    pos_exp = 32'h8000_0000;
    pulse(pos_exp);
    pulse($urandom);
    rd(ADDR_CAPTURED_POSITION, pos_exp);
    rd(ADDR_EVENT_COUNT, 32'h0000_0001);
    rd(ADDR_ACTIVATION, 32'h0000_0000);
    check({31'h0, capture_armed}, 32'h0000_0000);
    // A pulse while the clock enable is low must leave no trace
    wr(ADDR_EDGE_SELECT, 32'h0000_0001);
    wr(ADDR_ACTIVATION, {16'h0000, ACT_CONTINUOUS});
    rd(ADDR_ACTIVATION, {16'h0000, ACT_CONTINUOUS});
    clk_en <= 1'b0;
    pulse($urandom);
    clk_en <= 1'b1;
    rd(ADDR_EVENT_COUNT, 32'h0000_0000);
    pos_exp = $urandom;
    pulse(pos_exp);
    rd(ADDR_CAPTURED_POSITION, pos_exp);
    rd(ADDR_EVENT_COUNT, 32'h0000_0001);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_EVENT_COUNT, 32'h0000_0000);
    rd(ADDR_EDGE_SELECT, 32'h0000_0000);
    check({31'h0, capture_armed}, 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire
